// ---- ddr3_command_strobe_timing.sv ----
// module: read strobe framing and command timing monitor on the memory side
`timescale 1ns/100ps
`default_nettype none
module ddr3_command_strobe_timing
	import ddr3_strobe_pkg::*;
#(
	parameter int WIDTH = ddr3_strobe_pkg::DATA_WIDTH,
	parameter int DEPTH = ddr3_strobe_pkg::FIFO_DEPTH,
	parameter logic [7:0] READ_LATENCY = ddr3_strobe_pkg::READ_LATENCY_RST,
	parameter logic [7:0] BURST_LEN = ddr3_strobe_pkg::BURST_LEN_RST
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic [2:0] cmdCode,
	input wire logic rdValid,
	output logic rdReady,
	input wire logic [WIDTH-1:0] rdData,
	output logic strobeOut,
	output logic strobeOe,
	output logic [WIDTH-1:0] dqOut,
	output logic dqOe,
	input wire logic strobeIn,
	output logic spacingError
);
	import ddr3_strobe_pkg::*;

	// ************************************************************
	// link clock sampling
	// ************************************************************
	logic [2:0] linkSync_r, linkSync_nxt;
	logic linkLevel_r, linkLevel_nxt;
	logic [2:0] strobeSync_r, strobeSync_nxt;
	logic [2:0] cmdSync0_r, cmdSync1_r, cmdSync2_r;
	logic [2:0] cmdSync0_nxt, cmdSync1_nxt, cmdSync2_nxt;
	logic linkRise, linkFall;
	cmd_e cmdNow;

	// three stages; a change counts only once stages two and three agree
	always_comb begin
		linkSync_nxt = {linkSync_r[1:0], linkClk};
		strobeSync_nxt = {strobeSync_r[1:0], strobeIn};
		cmdSync0_nxt = cmdCode;
		cmdSync1_nxt = cmdSync0_r;
		cmdSync2_nxt = cmdSync1_r;
		linkLevel_nxt = linkLevel_r;
		if (linkSync_r[1] == linkSync_r[2]) begin
			linkLevel_nxt = linkSync_r[2];
		end
	end
	assign linkRise = (linkLevel_nxt && !linkLevel_r);
	assign linkFall = (!linkLevel_nxt && linkLevel_r);
	assign cmdNow = cmd_e'(cmdSync2_r);

	always_ff @(posedge mclk) begin
		if (rst) begin
			linkSync_r <= '0;
			strobeSync_r <= '0;
			cmdSync0_r <= '0;
			cmdSync1_r <= '0;
			cmdSync2_r <= '0;
			linkLevel_r <= 1'b0;
		end else begin
			linkSync_r <= linkSync_nxt;
			strobeSync_r <= strobeSync_nxt;
			cmdSync0_r <= cmdSync0_nxt;
			cmdSync1_r <= cmdSync1_nxt;
			cmdSync2_r <= cmdSync2_nxt;
			linkLevel_r <= linkLevel_nxt;
		end
	end

	// ************************************************************
	// command spacing watch
	// ************************************************************
	logic [7:0] sinceMrs_r, sinceMrs_nxt, sinceCol_r, sinceCol_nxt;
	logic [7:0] sinceRead_r, sinceRead_nxt, sinceWrite_r, sinceWrite_nxt;
	logic spacingError_r, spacingError_nxt;

	// counters saturate so a long idle never wraps into a false error
	function automatic logic [7:0] bump(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction : bump

	// the far side keeps these spacings; a breach is only flagged, sticky
	always_comb begin
		sinceMrs_nxt = sinceMrs_r;
		sinceCol_nxt = sinceCol_r;
		sinceRead_nxt = sinceRead_r;
		sinceWrite_nxt = sinceWrite_r;
		spacingError_nxt = spacingError_r;
		if (linkRise) begin
			sinceMrs_nxt = bump(sinceMrs_r);
			sinceCol_nxt = bump(sinceCol_r);
			sinceRead_nxt = bump(sinceRead_r);
			sinceWrite_nxt = bump(sinceWrite_r);
			case (cmdNow)
				CMD_MRS: begin
					if (sinceMrs_r < 8'(MRD_CYCLES)) spacingError_nxt = 1'b1;
					sinceMrs_nxt = 8'h01;
				end
				CMD_READ: begin
					if (sinceCol_r < 8'(CCD_CYCLES)) spacingError_nxt = 1'b1;
					if (sinceWrite_r < 8'(WTR_LINK)) spacingError_nxt = 1'b1;
					if (sinceMrs_r < 8'(MOD_LINK)) spacingError_nxt = 1'b1;
					sinceCol_nxt = 8'h01;
					sinceRead_nxt = 8'h01;
				end
				CMD_WRITE: begin
					if (sinceCol_r < 8'(CCD_CYCLES)) spacingError_nxt = 1'b1;
					if (sinceMrs_r < 8'(MOD_LINK)) spacingError_nxt = 1'b1;
					sinceCol_nxt = 8'h01;
					sinceWrite_nxt = 8'h01;
				end
				CMD_PRE: begin
					if (sinceRead_r < 8'(RTP_LINK)) spacingError_nxt = 1'b1;
					if (sinceMrs_r < 8'(MOD_LINK)) spacingError_nxt = 1'b1;
				end
				CMD_OTHER: begin
					if (sinceMrs_r < 8'(MOD_LINK)) spacingError_nxt = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end
	assign spacingError = spacingError_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sinceMrs_r <= 8'hff;
			sinceCol_r <= 8'hff;
			sinceRead_r <= 8'hff;
			sinceWrite_r <= 8'hff;
			spacingError_r <= 1'b0;
		end else begin
			sinceMrs_r <= sinceMrs_nxt;
			sinceCol_r <= sinceCol_nxt;
			sinceRead_r <= sinceRead_nxt;
			sinceWrite_r <= sinceWrite_nxt;
			spacingError_r <= spacingError_nxt;
		end
	end

	// ************************************************************
	// read strobe framer
	// ************************************************************
	typedef enum {ST_IDLE, ST_WAIT, ST_PRE, ST_BURST, ST_POST} strobe_e;
	strobe_e state_r, state_nxt;
	logic [7:0] count_r, count_nxt;
	logic strobeOut_r, strobeOut_nxt, strobeOe_r, strobeOe_nxt;
	logic [WIDTH-1:0] dqOut_r, dqOut_nxt;
	logic dqOe_r, dqOe_nxt;
	logic fifoValid, fifoPop;
	logic [WIDTH-1:0] fifoData;

	// read words queue here; a full fifo stalls the source via rdReady
	strobe_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.inValid(rdValid),
		.inReady(rdReady),
		.inData(rdData),
		.outValid(fifoValid),
		.outReady(fifoPop),
		.outData(fifoData)
	);

	// one word is launched on each link edge during the burst
	// the first word leaves on the rise that ends the preamble, so it must pop there too
	assign fifoPop = fifoValid && (((state_r == ST_PRE) && linkRise) ||
		((state_r == ST_BURST) && (linkRise || linkFall)));

	// a read waits RL-1 clocks, preambles one clock, bursts BL/2, the last half clock being the postamble
	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		strobeOut_nxt = strobeOut_r;
		strobeOe_nxt = strobeOe_r;
		dqOut_nxt = dqOut_r;
		dqOe_nxt = dqOe_r;
		case (state_r)
			ST_IDLE: begin
				if (linkRise && cmdNow == CMD_READ) begin
					state_nxt = ST_WAIT;
					count_nxt = READ_LATENCY - 8'(PRE_LINK) - 8'h01;
				end
			end
			ST_WAIT: begin
				if (linkRise) begin
					if (count_r == 8'h00) begin
						state_nxt = ST_PRE;
						strobeOe_nxt = 1'b1;
						strobeOut_nxt = 1'b0;
						count_nxt = 8'(PRE_LINK);
					end else begin
						count_nxt = count_r - 8'h01;
					end
				end
			end
			ST_PRE: begin
				// whole-clock preamble covers the 0.9 clock minimum
				if (linkRise) begin
					state_nxt = ST_BURST;
					// last beat leaves on a fall edge; its low half is the postamble
					count_nxt = BURST_LEN - 8'h02;
					strobeOut_nxt = 1'b1;
					dqOe_nxt = 1'b1;
					dqOut_nxt = fifoValid ? fifoData : DATA_RST;
				end
			end
			ST_BURST: begin
				if (linkRise || linkFall) begin
					strobeOut_nxt = linkRise;
					dqOut_nxt = fifoValid ? fifoData : DATA_RST;
					if (count_r == 8'h00) begin
						state_nxt = ST_POST;
						strobeOut_nxt = 1'b0;
					end else begin
						count_nxt = count_r - 8'h01;
					end
				end
			end
			ST_POST: begin
				// release lands at RL + BL/2 after the read
				if (linkRise) begin
					state_nxt = ST_IDLE;
					strobeOe_nxt = 1'b0;
					dqOe_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	assign strobeOut = strobeOut_r;
	assign strobeOe = strobeOe_r;
	assign dqOut = dqOut_r;
	assign dqOe = dqOe_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			count_r <= 8'h00;
			strobeOut_r <= 1'b0;
			strobeOe_r <= 1'b0;
			dqOut_r <= DATA_RST;
			dqOe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
			strobeOut_r <= strobeOut_nxt;
			strobeOe_r <= strobeOe_nxt;
			dqOut_r <= dqOut_nxt;
			dqOe_r <= dqOe_nxt;
		end
	end
	// write strobe framing is the controller's; strobeSync_r is kept for observation
endmodule : ddr3_command_strobe_timing
`default_nettype wire

// ---- ddr3_strobe_pkg.sv ----
// package: command codes, strobe timing counts and latency defaults for the strobe framer
package ddr3_strobe_pkg;
	// command encodings seen on the command port
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_MRS,
		CMD_READ,
		CMD_WRITE,
		CMD_PRE,
		CMD_OTHER
	} cmd_e;
	localparam int unsigned CLK_PERIOD_PS = 100000;
	localparam int unsigned LINK_SYNC_STAGES = 3;
	localparam int unsigned MRD_CYCLES = 4;
	localparam int unsigned CCD_CYCLES = 4;
	localparam int unsigned RTP_CYCLES_MIN = 4;
	localparam int unsigned RTP_PS = 7500;
	localparam int unsigned MOD_CYCLES_MIN = 12;
	localparam int unsigned MOD_PS = 15000;
	// shortest wait between commands, in link clocks
	localparam int unsigned RTP_LINK = RTP_CYCLES_MIN;
	localparam int unsigned WTR_LINK = RTP_CYCLES_MIN;
	localparam int unsigned MOD_LINK = MOD_CYCLES_MIN;
	// preamble held for one whole link clock; the framer holds the postamble only for the low half of the last beat
	localparam int unsigned PRE_LINK = 1;
	localparam int unsigned PST_LINK = 1;
	localparam logic [7:0] READ_LATENCY_RST = 8'h05;
	localparam logic [7:0] BURST_LEN_RST = 8'h08;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned DATA_WIDTH = 16;
endpackage : ddr3_strobe_pkg

// ---- strobe_fifo.sv ----
// module: small valid/ready fifo holding read burst words
`timescale 1ns/100ps
`default_nettype none
module strobe_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic push, pop;

	// full and empty come straight from the occupancy count
	assign inReady = (int'(count_r) < DEPTH);
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// pointer arithmetic wraps at depth
	always_comb begin
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (push) begin
			wrPtr_nxt = (int'(wrPtr_r) == DEPTH - 1) ? '0 : wrPtr_r + 1'b1;
		end
		if (pop) begin
			rdPtr_nxt = (int'(rdPtr_r) == DEPTH - 1) ? '0 : rdPtr_r + 1'b1;
		end
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	// storage has no reset; only the pointers and the count need a defined value
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end
endmodule : strobe_fifo
`default_nettype wire

// ---- ddr3_strobe_checker_assertions.sv ----
// checker: read strobe framing and spacing flag assertions
`timescale 1ns/100ps
`default_nettype none
module ddr3_strobe_checker #(
	parameter int WIDTH = 16,
	parameter logic [7:0] READ_LATENCY = 8'h05,
	parameter logic [7:0] BURST_LEN = 8'h08
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic [2:0] cmdCode,
	input wire logic rdValid,
	input wire logic rdReady,
	input wire logic [WIDTH-1:0] rdData,
	input wire logic strobeOut,
	input wire logic strobeOe,
	input wire logic [WIDTH-1:0] dqOut,
	input wire logic dqOe,
	input wire logic strobeIn,
	input wire logic spacingError
);
	// the bench link clock is eight system clocks long
	localparam int LINK_MCLK = 8;
	logic [7:0] burstCnt_r;
	logic [7:0] burstCnt_nxt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// *********************************
	// burst length counter
	// *********************************
	always_comb begin
		burstCnt_nxt = dqOe ? burstCnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge mclk) begin
		burstCnt_r <= rst ? 8'h00 : burstCnt_nxt;
	end
	// preamble holds low one link clock, then data starts high
	a_pre: assert property (p_pre) else $error("read preamble wrong");
	property p_pre;
		$rose(strobeOe) |-> (strobeOe && !strobeOut && !dqOe)[*8] ##1 (dqOe && strobeOut);
	endproperty
	a_tog: assert property (p_tog) else $error("strobe half period wrong");
	property p_tog;
		$rose(strobeOut) |-> strobeOut[*4] ##1 !strobeOut;
	endproperty
	a_len: assert property (p_len) else $error("burst length wrong");
	property p_len;
		$fell(dqOe) |-> burstCnt_r == 8'(BURST_LEN * LINK_MCLK / 2);
	endproperty
	a_pst: assert property (p_pst) else $error("read postamble wrong");
	property p_pst;
		$fell(strobeOut) && dqOe |-> (strobeOe && !strobeOut)[*4] ##1 (strobeOut || !strobeOe);
	endproperty
	a_rel: assert property (p_rel) else $error("strobe active while released");
	property p_rel;
		!strobeOe |-> !strobeOut && !dqOe;
	endproperty
	a_dq: assert property (p_dq) else $error("data driven without strobe");
	property p_dq;
		dqOe |-> strobeOe;
	endproperty
	a_err: assert property (p_err) else $error("spacing flag dropped");
	property p_err;
		spacingError |=> spacingError;
	endproperty
	a_stab: assert property (p_stab) else $error("data moved between strobe edges");
	property p_stab;
		dqOe && !$changed(strobeOut) |-> $stable(dqOut);
	endproperty
endmodule : ddr3_strobe_checker
bind ddr3_command_strobe_timing ddr3_strobe_checker #(.WIDTH(WIDTH),
	.READ_LATENCY(READ_LATENCY), .BURST_LEN(BURST_LEN)) chk (.mclk(mclk), .rst(rst),
	.linkClk(linkClk), .cmdCode(cmdCode), .rdValid(rdValid), .rdReady(rdReady),
	.rdData(rdData), .strobeOut(strobeOut), .strobeOe(strobeOe), .dqOut(dqOut),
	.dqOe(dqOe), .strobeIn(strobeIn), .spacingError(spacingError));
`default_nettype wire

// ---- ddr3_ctrl_model.sv ----
// partner model: controller command clock, spaced commands and write strobe
`timescale 1ns/100ps
`default_nettype none
module ddr3_ctrl_model (
	output logic linkClk,
	output logic [2:0] cmdCode,
	output logic strobeIn
);
	import ddr3_strobe_pkg::*;
	time takeTime = 0;
	int sinceMrs = 100;
	int sinceCol = 100;
	int sinceWr = 100;
	int sinceRd = 100;
	initial begin
		cmdCode = CMD_NOP;
		strobeIn = 1'b0;
		linkClk = 1'b0;
	end
	// command clock runs free, as the memory clock does
	always #400 linkClk = ~linkClk;
	// history in link clocks, saturating so long idles never wrap
	always @(posedge linkClk) begin
		sinceMrs = (cmdCode == CMD_MRS) ? 0 : sinceMrs + (sinceMrs < 100);
		sinceCol = (cmdCode inside {CMD_READ, CMD_WRITE}) ? 0 : sinceCol + (sinceCol < 100);
		sinceWr = (cmdCode == CMD_WRITE) ? 0 : sinceWr + (sinceWr < 100);
		sinceRd = (cmdCode == CMD_READ) ? 0 : sinceRd + (sinceRd < 100);
	end
	// ns terms are below the cycle terms at this clock, so cycle counts rule
	function automatic bit legal(input cmd_e c);
		legal = 1'b1;
		if (c == CMD_MRS && sinceMrs + 1 < MRD_CYCLES) legal = 1'b0;
		if (c != CMD_MRS && sinceMrs + 1 < MOD_LINK) legal = 1'b0;
		if (c inside {CMD_READ, CMD_WRITE} && sinceCol + 1 < CCD_CYCLES) legal = 1'b0;
		if (c == CMD_READ && sinceWr + 1 < WTR_LINK) legal = 1'b0;
		if (c == CMD_PRE && sinceRd + 1 < RTP_LINK) legal = 1'b0;
	endfunction : legal
	// rush skips spacing and write framing, acting as a faulty controller
	task automatic issue(input cmd_e c, input bit rush);
		@(negedge linkClk);
		while (!rush && !legal(c)) @(negedge linkClk);
		cmdCode = c;
		@(posedge linkClk);
		takeTime = $time;
		@(negedge linkClk);
		cmdCode = CMD_NOP;
		if (c == CMD_WRITE && !rush) begin
			@(negedge linkClk);
			repeat (8) begin
				strobeIn = ~strobeIn;
				#400;
			end
			#800;
			strobeIn = 1'b1;
		end
	endtask : issue
endmodule : ddr3_ctrl_model
`default_nettype wire

// ---- test_ddr3_command_strobe_timing.sv ----
// testbench: read strobe timing, read fifo and command spacing flag
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_ddr3_command_strobe_timing;
	import ddr3_strobe_pkg::*;
	localparam int LINK_NS = 800;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic rdValid = 1'b0;
	logic [15:0] rdData = 16'h0000;
	logic [15:0] dqOut;
	logic linkClk, rdReady, strobeOut, strobeOe, dqOe, strobeIn, spacingError;
	logic [2:0] cmdCode;
	int n_mismatch = 0;
	int checked = 0;
	always #50 mclk = ~mclk;
	ddr3_ctrl_model ctrl (.linkClk(linkClk), .cmdCode(cmdCode), .strobeIn(strobeIn));
	ddr3_command_strobe_timing dut (.mclk(mclk), .rst(rst), .linkClk(linkClk),
		.cmdCode(cmdCode), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
		.strobeOut(strobeOut), .strobeOe(strobeOe), .dqOut(dqOut), .dqOe(dqOe),
		.strobeIn(strobeIn), .spacingError(spacingError));
	task report_and_stop;
		$display("mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic do_reset;
		@(negedge mclk) rst = 1'b1;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
	endtask : do_reset
	// bounded wait for a level, sampled away from the clock edge
	task automatic wait_lvl(ref logic s, input logic v);
		int i;
		for (i = 0; i < 400 && s !== v; i++) @(negedge mclk);
	endtask : wait_lvl
	// ***************************
	// scenarios
	// ***************************
	task automatic t_reset;
		`CHK(strobeOe, 1'b0)
		`CHK(spacingError, 1'b0)
		`CHK(rdReady, 1'b1)
	endtask : t_reset
	// fill until refused, then one read drains four words and pads with zero
	task automatic t_read;
		int pushed;
		int j;
		time t0;
		pushed = 0;
		while (rdReady === 1'b1 && pushed < 8) begin
			rdValid = 1'b1;
			rdData = 16'h0a50 + 16'(pushed);
			@(negedge mclk);
			pushed++;
		end
		rdValid = 1'b0;
		`CHK(pushed, FIFO_DEPTH)
		ctrl.issue(CMD_READ, 1'b0);
		t0 = ctrl.takeTime;
		wait_lvl(strobeOe, 1'b1);
		`CHK(($time - t0) / LINK_NS, 64'(READ_LATENCY_RST - 8'h01))
		wait_lvl(dqOe, 1'b1);
		for (j = 0; j < 8; j++) begin
			repeat (2) @(negedge mclk);
			`CHK(dqOut, (j < FIFO_DEPTH) ? 16'h0a50 + 16'(j) : DATA_RST)
			repeat (2) @(negedge mclk);
		end
		wait_lvl(strobeOe, 1'b0);
		`CHK(($time - t0) / LINK_NS, 64'(READ_LATENCY_RST + BURST_LEN_RST / 2))
	endtask : t_read
	task automatic t_spacing_ok;
		do_reset();
		ctrl.issue(CMD_MRS, 1'b0);
		ctrl.issue(CMD_MRS, 1'b0);
		ctrl.issue(CMD_WRITE, 1'b0);
		ctrl.issue(CMD_READ, 1'b0);
		ctrl.issue(CMD_PRE, 1'b0);
		ctrl.issue(CMD_OTHER, 1'b0);
		repeat (8) @(negedge mclk);
		`CHK(spacingError, 1'b0)
	endtask : t_spacing_ok
	// each pair lands two link clocks apart, too close for every entry
	task automatic t_spacing_bad;
		cmd_e first[5] = '{CMD_MRS, CMD_READ, CMD_WRITE, CMD_WRITE, CMD_MRS};
		cmd_e second[5] = '{CMD_MRS, CMD_PRE, CMD_READ, CMD_WRITE, CMD_OTHER};
		int k;
		for (k = 0; k < 5; k++) begin
			do_reset();
			ctrl.issue(first[k], 1'b1);
			ctrl.issue(second[k], 1'b1);
			repeat (8) @(negedge mclk);
			`CHK(spacingError, 1'b1)
		end
	endtask : t_spacing_bad
	initial begin
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		t_reset();
		t_read();
		t_spacing_ok();
		t_spacing_bad();
		report_and_stop();
	end
	// watchdog: the scenarios need well under a quarter of this span
	initial begin
		#1000000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : test_ddr3_command_strobe_timing
`default_nettype wire
